//--- rtl/sfa_link_align.sv
// Frame clock and multi-frame clock alignment and link break control
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sfa_cfg.svh"
module sfa_link_align (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        sysref,
  input  wire logic        sync_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             link_up,
  output logic             ila_active,
  output logic             scramble_en,
  output logic             two_lane,
  output logic [31:0]      ila_params
);
  // ==========================================================
  // Registers
  // ==========================================================
  logic [5:0]  ctrl;
  logic [4:0]  k_len;
  logic [1:0]  frame_len;
  logic [1:0]  clk_div;
  logic [7:0]  phase_adj;
  logic [15:0] break_cnt;
  logic        sysref_q;
  logic        gate_q;
  logic        div_wr;
  logic        k_wr;
  logic        frame_end;
  logic        mf_end;
  logic        on_boundary;
  logic        sysref_edge;
  logic        misalign;
  logic        run;
  logic        brk;
  logic [1:0]  ila_mf;
  sfa_pkg::sfa_link_t state;
  sfa_pkg::sfa_link_t next_state;
  // Address decode helper, used by both write and read paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction
  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic       wr_go;
  logic       wr_hit;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  // Address and data taken in either order, one write outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SFA_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SFA_RESP_OKAY : `SFA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Only writable offsets answer OKAY
  always_comb begin
    if (addr_is(aw_addr, `SFA_REG_CTRL)) begin
      wr_hit = 1'b1;
    end else if (addr_is(aw_addr, `SFA_REG_KCFG)) begin
      wr_hit = 1'b1;
    end else if (addr_is(aw_addr, `SFA_REG_DIV)) begin
      wr_hit = 1'b1;
    end else if (addr_is(aw_addr, `SFA_REG_PHASE)) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end
  assign div_wr = wr_go && addr_is(aw_addr, `SFA_REG_DIV) && s_axi_wstrb[0];
  assign k_wr   = wr_go && addr_is(aw_addr, `SFA_REG_KCFG) && s_axi_wstrb[0];
  // Control register; low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `SFA_CTRL_RST;
    end else if (ce && wr_go && addr_is(aw_addr, `SFA_REG_CTRL) && s_axi_wstrb[0]) begin
      ctrl <= w_data[5:0];
    end
  end
  // Multi-frame length; too short a K in two-lane mode is refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      k_len     <= `SFA_K_RST;
      frame_len <= `SFA_F_RST;
    end else if (ce && k_wr) begin
      if (!(ctrl[`SFA_CTRL_TWOLANE] && w_data[4:0] < `SFA_K_MIN_2LANE)) begin
        k_len     <= w_data[4:0];
        frame_len <= w_data[9:8];
      end
    end
  end
  // Divider and phase adjust; any divider write with the low byte lane breaks the link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_div   <= `SFA_DIV_RST;
      phase_adj <= 8'h00;
    end else if (ce && wr_go && s_axi_wstrb[0]) begin
      if (div_wr) begin
        clk_div <= w_data[1:0];
      end
      if (addr_is(aw_addr, `SFA_REG_PHASE)) begin
        phase_adj <= w_data[7:0];
      end
    end
  end

  // ==========================================================
  // SYSREF detection and phase counters
  // ==========================================================
  // Gate opening with SYSREF already high looks like an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysref_q <= 1'b0;
      gate_q   <= 1'b0;
    end else if (ce) begin
      sysref_q <= sysref;
      gate_q   <= ctrl[`SFA_CTRL_GATE];
    end
  end
  assign sysref_edge = ctrl[`SFA_CTRL_GATE] && sysref && (!sysref_q || !gate_q);
  assign misalign    = sysref_edge && !on_boundary;
  assign run = !ctrl[`SFA_CTRL_PWRDN] && !ctrl[`SFA_CTRL_SLEEP]
             && ctrl[`SFA_CTRL_CLKOK];
  sfa_phase_counter u_phase (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .run         (run),
    .frame_len   (frame_len),
    .k_len       (k_len),
    .align       (misalign),
    .frame_end   (frame_end),
    .mf_end      (mf_end),
    .on_boundary (on_boundary)
  );

  // ==========================================================
  // Link state
  // ==========================================================
  // Phase adjust writes deliberately absent here, so the link stays up
  assign brk = !run || div_wr || k_wr || misalign || !sync_n;

  always_comb begin
    next_state = state;
    case (state)
      sfa_pkg::SFA_LINK_DOWN: begin
        if (!brk) begin
          next_state = sfa_pkg::SFA_LINK_CGS;
        end
      end
      sfa_pkg::SFA_LINK_CGS: begin
        // Receiver releases sync; ILA starts on a multi-frame edge
        if (mf_end) begin
          next_state = sfa_pkg::SFA_LINK_ILA;
        end
      end
      sfa_pkg::SFA_LINK_ILA: begin
        if (mf_end && ila_mf == `SFA_ILA_MF) begin
          next_state = sfa_pkg::SFA_LINK_DATA;
        end
      end
      sfa_pkg::SFA_LINK_DATA: begin
        next_state = sfa_pkg::SFA_LINK_DATA;
      end
      default: begin
        next_state = sfa_pkg::SFA_LINK_DOWN;
      end
    endcase
    if (brk) begin
      next_state = sfa_pkg::SFA_LINK_DOWN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= sfa_pkg::SFA_LINK_DOWN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Multi-frames spent in the alignment sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ila_mf <= 2'h0;
    end else if (ce) begin
      if (state != sfa_pkg::SFA_LINK_ILA) begin
        ila_mf <= 2'h0;
      end else if (mf_end) begin
        ila_mf <= ila_mf + 2'h1;
      end
    end
  end

  // Count link breaks in any state but down; saturates rather than wrapping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_cnt <= 16'h0000;
    end else if (ce && state != sfa_pkg::SFA_LINK_DOWN && brk && break_cnt != 16'hFFFF) begin
      break_cnt <= break_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Outputs; frame and multi-frame strobes stay internal
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_up     <= 1'b0;
      ila_active  <= 1'b0;
      scramble_en <= 1'b0;
      two_lane    <= 1'b0;
      ila_params  <= 32'h0000_0000;
    end else if (ce) begin
      link_up     <= (next_state == sfa_pkg::SFA_LINK_DATA);
      ila_active  <= (next_state == sfa_pkg::SFA_LINK_ILA);
      scramble_en <= ctrl[`SFA_CTRL_SCRAM];
      two_lane    <= ctrl[`SFA_CTRL_TWOLANE];
      // Fixed N, N', CS, CF may not match every data mode; top five bits unused
      ila_params  <= {5'h00, `SFA_ILA_CF, `SFA_ILA_CS, `SFA_ILA_NP, `SFA_ILA_N,
                      1'b0, ctrl[`SFA_CTRL_SCRAM], k_len, frame_len, ctrl[`SFA_CTRL_TWOLANE]};
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    if (addr_is(s_axi_araddr, `SFA_REG_CTRL)) begin
      rd_mux = {26'h000_0000, ctrl};
    end else if (addr_is(s_axi_araddr, `SFA_REG_KCFG)) begin
      rd_mux = {22'h00_0000, frame_len, 3'h0, k_len};
    end else if (addr_is(s_axi_araddr, `SFA_REG_DIV)) begin
      rd_mux = {30'h0000_0000, clk_div};
    end else if (addr_is(s_axi_araddr, `SFA_REG_PHASE)) begin
      rd_mux = {24'h00_0000, phase_adj};
    end else if (addr_is(s_axi_araddr, `SFA_REG_STATUS)) begin
      rd_mux = {27'h000_0000, on_boundary, run, state};
    end else if (addr_is(s_axi_araddr, `SFA_REG_ILA0)) begin
      rd_mux = ila_params;
    end else if (addr_is(s_axi_araddr, `SFA_REG_BREAKS)) begin
      rd_mux = {16'h0000, break_cnt};
    end else begin
      rd_hit = 1'b0;
      rd_mux = 32'h0000_0000;
    end
  end

  // One read outstanding; answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SFA_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? `SFA_RESP_OKAY : `SFA_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- rtl/sfa_cfg.svh
// Constants for the frame and multi-frame clock alignment block
`ifndef SFA_CFG_SVH
`define SFA_CFG_SVH
// Register byte offsets
`define SFA_REG_CTRL      8'h00
`define SFA_REG_KCFG      8'h04
`define SFA_REG_DIV       8'h08
`define SFA_REG_PHASE     8'h0C
`define SFA_REG_STATUS    8'h10
`define SFA_REG_ILA0      8'h14
`define SFA_REG_BREAKS    8'h18
// Control field positions
`define SFA_CTRL_PWRDN    0
`define SFA_CTRL_SLEEP    1
`define SFA_CTRL_GATE     2
`define SFA_CTRL_SCRAM    3
`define SFA_CTRL_TWOLANE  4
`define SFA_CTRL_CLKOK    5
// Reset values and the two-lane K minimum
`define SFA_CTRL_RST      6'h20
`define SFA_K_RST         5'h14
`define SFA_F_RST         2'h1
`define SFA_DIV_RST       2'h0
`define SFA_K_MIN_2LANE   5'h11
// ILA parameter fields reported to the link
`define SFA_ILA_N         5'h0F
`define SFA_ILA_NP        5'h0F
`define SFA_ILA_CS        2'h0
`define SFA_ILA_CF        5'h00
// Link restart timing: index of the last ILA multi-frame, so ILA spans four multi-frames
`define SFA_ILA_MF        2'h3
`define SFA_RESP_OKAY     2'h0
`define SFA_RESP_SLVERR   2'h2
`endif

//--- rtl/sfa_pkg.sv
// Types shared by the alignment block files
package sfa_pkg;
  typedef enum logic [2:0] {
    SFA_LINK_DOWN = 3'b000,
    SFA_LINK_CGS  = 3'b001,
    SFA_LINK_ILA  = 3'b010,
    SFA_LINK_DATA = 3'b011
  } sfa_link_t;
endpackage

//--- rtl/sfa_phase_counter.sv
// Frame and multi-frame phase counters with SYSREF alignment
`timescale 1ns/1ps
module sfa_phase_counter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] frame_len,
  input  wire logic [4:0] k_len,
  input  wire logic       align,
  output logic            frame_end,
  output logic            mf_end,
  output logic            on_boundary
);
  logic [1:0] octet_cnt;
  logic [4:0] frame_cnt;

  // Boundary means both counters sit at zero
  assign on_boundary = (octet_cnt == 2'h0) && (frame_cnt == 5'h00);
  assign frame_end   = run && (octet_cnt == frame_len - 2'h1);
  assign mf_end      = frame_end && (frame_cnt == k_len - 5'h01);

  // Stopped counters hold the default phase until restarted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      octet_cnt <= 2'h0;
      frame_cnt <= 5'h00;
    end else if (ce) begin
      if (align || !run) begin
        octet_cnt <= 2'h0;
        frame_cnt <= 5'h00;
      end else if (frame_end) begin
        octet_cnt <= 2'h0;
        frame_cnt <= mf_end ? 5'h00 : frame_cnt + 5'h01;
      end else begin
        octet_cnt <= octet_cnt + 2'h1;
      end
    end
  end
endmodule

//--- tb/sfa_link_align_sva.sv
// Concurrent checks on the ports of the alignment block
`timescale 1ns/1ps
module sfa_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        sync_n,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        link_up,
  input wire logic        ila_active,
  input wire logic        two_lane,
  input wire logic [31:0] ila_params
);
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ====
  // Steps of a read and of a sync request
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  sequence sync_seen;
    !sync_n && ce;
  endsequence
  // ====
  // Link state checks
  sync_drop_a: assert property (sync_seen |-> ##[1:2] !link_up)
    else $error("link stayed up on sync request");
  ila_first_a: assert property ($rose(link_up) |-> $past(ila_active))
    else $error("data state entered without lane alignment");
  state_excl_a: assert property (!(link_up && ila_active))
    else $error("alignment and data state at once");
  lane_k_a: assert property (two_lane && link_up |-> ila_params[7:3] >= 5'h11)
    else $error("short multi-frame with two lanes");
  // ====
  // Bus handshake checks; the answer must not slip while unaccepted
  aw_pulse_a: assert property (s_axi_awready && ce |=> !s_axi_awready)
    else $error("write address ready held");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  rd_lat_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind sfa_link_align sfa_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .ce(ce),
  .sync_n(sync_n),
  .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .link_up(link_up),
  .ila_active(ila_active),
  .two_lane(two_lane),
  .ila_params(ila_params)
);

//--- tb/sfa_rx_model.sv
// Serial receiver and SYSREF source model facing the alignment block
`timescale 1ns/1ps
module sfa_rx_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic req_sync,
  input  wire logic ref_lvl,
  output logic      sync_n,
  output logic      sysref
);
  // Sync held low through reset and on command; release lands on an edge
  always_ff @(posedge aclk) begin
    sync_n <= aresetn && !req_sync;
  end
  // Pulse level one cycle late, so spacing stays a whole count of cycles
  always_ff @(posedge aclk) begin
    sysref <= ref_lvl;
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the frame clock alignment block
`timescale 1ns/1ps
`include "sfa_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
  // ====
  // Stimulus and observed signals
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        ce = 1'h1;
  logic        req_sync = 1'h0;
  logic        ref_lvl = 1'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        sync_n, sysref, awready, wready, bvalid, arready, rvalid;
  logic        link_up, ila_active, scramble_en, two_lane;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, ila_params, rd;
  int          fails = 0;
  int          checked = 0;
  time         t0;
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  sfa_link_align u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sysref(sysref),
    .sync_n(sync_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_up(link_up), .ila_active(ila_active), .scramble_en(scramble_en),
    .two_lane(two_lane), .ila_params(ila_params));
  sfa_rx_model u_rx (.aclk(aclk), .aresetn(aresetn), .req_sync(req_sync),
    .ref_lvl(ref_lvl), .sync_n(sync_n), .sysref(sysref));
  // ====
  // Shared helpers
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Late bready lets the slave hold its answer for a while
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (n == 4) bready <= 1'h1;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
      if (n == 3) rready <= 1'h1;
    end while (!(rvalid && rready));
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  task automatic up;
    int n;
    n = 0;
    while (!link_up && n < 600) begin
      @(posedge aclk);
      n++;
    end
    `CHK("link_up", 1'h1, link_up)
  endtask
  task automatic pulse;
    t0 = $time;
    ref_lvl <= 1'h1;
    step(2);
    ref_lvl <= 1'h0;
    step(1);
  endtask
  // ====
  // Scenarios
  task automatic t_rst;
    rdr(`SFA_REG_CTRL);
    `CHK("ctrl", 32'h0000_0020, rd)
    rdr(`SFA_REG_KCFG);
    `CHK("kcfg", 32'h0000_0114, rd)
    up();
    `CHK("ila_k", 5'h14, ila_params[7:3])
    `CHK("ila_n", `SFA_ILA_N, ila_params[14:10])
    rdr(`SFA_REG_STATUS);
    `CHK("state", 3'h3, rd[2:0])
    $display("test reset done");
  endtask
  task automatic t_bad;
    rdr(8'h1C);
    `CHK("rd_resp", `SFA_RESP_SLVERR, rs)
    `CHK("rd_data", 32'h0000_0000, rd)
    wr(8'h1C, 32'h0000_00FF);
    `CHK("wr_resp", `SFA_RESP_SLVERR, rs)
    $display("test unmapped done");
  endtask
  // Phase tuning and a frozen clock enable must leave the link alone
  task automatic t_keep;
    wr(`SFA_REG_PHASE, 32'h0000_005A);
    step(2);
    `CHK("phase_link", 1'h1, link_up)
    rdr(`SFA_REG_PHASE);
    `CHK("phase", 32'h0000_005A, rd)
    ce <= 1'h0;
    step(8);
    ce <= 1'h1;
    step(1);
    `CHK("ce_link", 1'h1, link_up)
    $display("test keep done");
  endtask
  task automatic t_sync;
    req_sync <= 1'h1;
    step(4);
    `CHK("sync_link", 1'h0, link_up)
    req_sync <= 1'h0;
    up();
    $display("test sync done");
  endtask
  // Power-down, sleep, clock loss, divider and K writes all drop the link
  task automatic t_brk;
    logic [7:0]  ad [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h04};
    logic [31:0] dv [5] = '{32'h0000_0021, 32'h0000_0022, 32'h0000_0000,
                            32'h0000_0001, 32'h0000_0114};
    for (int i = 0; i < 5; i++) begin
      wr(ad[i], dv[i]);
      step(2);
      `CHK("brk_link", 1'h0, link_up)
      wr(`SFA_REG_CTRL, 32'h0000_0020);
      up();
    end
    // One break from the sync test plus one for each of the five above
    rdr(`SFA_REG_BREAKS);
    `CHK("breaks", 32'h0000_0006, rd)
    $display("test breaks done");
  endtask
  // Two pulses seven cycles apart: one at least is off the boundary
  task automatic t_ref;
    wr(`SFA_REG_CTRL, 32'h0000_0024);
    pulse();
    step(4);
    pulse();
    step(3);
    `CHK("ref_break", 1'h0, link_up)
    up();
    // Edge is seen one edge after a pulse call; counters read zero one edge later
    while ((($time - t0) / 10) % (`SFA_K_RST * `SFA_F_RST) != 1) @(posedge aclk);
    pulse();
    step(4);
    `CHK("ref_keep", 1'h1, link_up)
    wr(`SFA_REG_CTRL, 32'h0000_0020);
    // Gate opens with SYSREF already high, four edges on: three off the boundary
    ref_lvl <= 1'h1;
    while ((($time - t0) / 10) % (`SFA_K_RST * `SFA_F_RST) != 0) @(posedge aclk);
    wr(`SFA_REG_CTRL, 32'h0000_0024);
    step(1);
    `CHK("gate_edge", 1'h0, link_up)
    ref_lvl <= 1'h0;
    wr(`SFA_REG_CTRL, 32'h0000_0020);
    up();
    $display("test sysref done");
  endtask
  task automatic t_lane;
    wr(`SFA_REG_CTRL, 32'h0000_0038);
    wr(`SFA_REG_KCFG, 32'h0000_0110);
    rdr(`SFA_REG_KCFG);
    `CHK("k16", 32'h0000_0114, rd)
    wr(`SFA_REG_KCFG, 32'h0000_0111);
    rdr(`SFA_REG_KCFG);
    `CHK("k17", 32'h0000_0111, rd)
    `CHK("two_lane", 1'h1, two_lane)
    `CHK("scramble", 1'h1, scramble_en)
    `CHK("ila_scr", 1'h1, ila_params[8])
    $display("test lanes done");
  endtask
  // ====
  // Verdict, main sequence and watchdog
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    step(20);
    aresetn <= 1'h1;
    t_rst();
    t_bad();
    t_keep();
    t_sync();
    t_brk();
    t_ref();
    t_lane();
    give_verdict();
  end
  // Budget well above the expected run of well under two thousand cycles
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule
